// [hdl/synth_cal_pkg.sv]
package synth_cal_pkg;

  // ********************************
  // bus geometry
  // ********************************
  localparam int APB_ADDR_W = 18;
  localparam int APB_DATA_W = 32;

  // ********************************
  // register indices and byte addresses
  // ********************************
  localparam logic [15:0] IDX_CHARGE_PUMP_CAL = 16'hDF1C;
  localparam logic [15:0] IDX_VCO_CURRENT_CAL = 16'hDF1D;
  localparam logic [15:0] IDX_VCO_COARSE_CAP  = 16'hDF1E;

  localparam logic [APB_ADDR_W-1:0] ADDR_CHARGE_PUMP_CAL = {IDX_CHARGE_PUMP_CAL, 2'h0};
  localparam logic [APB_ADDR_W-1:0] ADDR_VCO_CURRENT_CAL = {IDX_VCO_CURRENT_CAL, 2'h0};
  localparam logic [APB_ADDR_W-1:0] ADDR_VCO_COARSE_CAP  = {IDX_VCO_COARSE_CAP, 2'h0};

  // ********************************
  // field positions
  // ********************************
  localparam int CP_CONFIG_LSB    = 6;
  localparam int CP_STAGE_EN_LSB  = 4;
  localparam int CP_CODE_LSB      = 0;
  localparam int VCO_CORE_BIT     = 5;
  localparam int VCO_CURRENT_LSB  = 0;
  localparam int VCO_CAP_LSB      = 0;

  // ********************************
  // reset values
  // ********************************
  localparam logic [1:0] RST_CP_CONFIG   = 2'h2;
  localparam logic [1:0] RST_CP_STAGE_EN = 2'h2;
  localparam logic [3:0] RST_CP_CODE     = 4'h9;
  localparam logic       RST_VCO_CORE    = 1'b0;
  localparam logic [4:0] RST_VCO_CURRENT = 5'h0A;
  localparam logic [5:0] RST_VCO_CAP     = 6'h20;

  // ********************************
  // charge pump scale: 2^(k/4) for k = 0..3, unsigned q8
  // ********************************
  localparam int          CP_FRAC_W  = 9;
  localparam int          CP_CURR_W  = 12;
  localparam logic [8:0]  CP_FRAC_0  = 9'h100;
  localparam logic [8:0]  CP_FRAC_1  = 9'h130;
  localparam logic [8:0]  CP_FRAC_2  = 9'h16A;
  localparam logic [8:0]  CP_FRAC_3  = 9'h1AF;

endpackage

// [hdl/cp_scale_if.sv]
interface cp_scale_if;
  logic [3:0]  code;
  logic [11:0] current;

  modport scaler (input code, output current);
  modport user   (output code, input current);
endinterface

// [hdl/cp_current_scaler.sv]
module cp_current_scaler
  import synth_cal_pkg::*;
(
  cp_scale_if.scaler sc
);

  // ********************************
  // exponential current multiplier
  // ********************************
  function automatic logic [CP_FRAC_W-1:0] frac_of(input logic [1:0] k);
    case (k)
      2'h0:    frac_of = CP_FRAC_0;
      2'h1:    frac_of = CP_FRAC_1;
      2'h2:    frac_of = CP_FRAC_2;
      default: frac_of = CP_FRAC_3;
    endcase
  endfunction

  // integer part of code/4 is a shift, the remainder a q8 factor
  assign sc.current = {3'h0, frac_of(sc.code[1:0])} << sc.code[3:2];

endmodule // cp_current_scaler

// [hdl/synth_calibration_regs.sv]
// Operation
// - charge pump calibration stage is skipped while its two-bit enable field is zero.
// - low four bits give charge pump current, base times two to code over four.
// - bit 5 selects vco core, zero low, one high; resets low.
// - five-bit vco current field holds calibration result and software override value.
// - six-bit capacitor array field resets to 100000; upper two bits read zero.
// - saved values written back by software are used directly, no new calibration.
// - all three registers return to reset on wake from either deepest sleep mode.
//
// Decided for this implementation: the APB interface to the registers.
module synth_calibration_regs
  import synth_cal_pkg::*;
(
  input  wire logic                  clock_i,
  input  wire logic                  rst_i,
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [APB_ADDR_W-1:0] paddr_i,
  input  wire logic [APB_DATA_W-1:0] pwdata_i,
  output logic      [APB_DATA_W-1:0] prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  input  wire logic                  deep_sleep_wake_i,
  input  wire logic                  cal_done_i,
  input  wire logic [3:0]            cal_cp_code_i,
  input  wire logic [4:0]            cal_vco_current_i,
  input  wire logic [5:0]            cal_vco_cap_i,
  output logic      [1:0]            cp_config_o,
  output logic                       charge_pump_cal_stage_run_o,
  output logic      [3:0]            cp_code_o,
  output logic      [11:0]           cp_current_o,
  output logic                       vco_high_core_select_o,
  output logic      [4:0]            vco_current_o,
  output logic      [5:0]            vco_cap_o
);

  // ********************************
  // register state
  // ********************************
  logic [1:0] cp_config;
  logic [1:0] charge_pump_cal_stage_enable;
  logic [3:0] cp_code;
  logic       vco_high_core_select;
  logic [4:0] vco_current;
  logic [5:0] vco_cap;

  logic       setup;
  logic       wr_cp;
  logic       wr_vco;
  logic       wr_cap;
  logic       stage_on;
  logic       clr;

  cp_scale_if sc ();

  cp_current_scaler u_scaler (
    .sc (sc)
  );

  // ********************************
  // address decode
  // ********************************
  function automatic logic [1:0] decode(input logic [APB_ADDR_W-1:0] a);
    case (a)
      ADDR_CHARGE_PUMP_CAL: decode = 2'h1;
      ADDR_VCO_CURRENT_CAL: decode = 2'h2;
      ADDR_VCO_COARSE_CAP:  decode = 2'h3;
      default:              decode = 2'h0;
    endcase
  endfunction

  // pready goes high one cycle after setup, so every access is one wait-free access phase
  assign setup  = psel_i && !penable_i;
  assign wr_cp  = psel_i && penable_i && pready_o && pwrite_i && decode(paddr_i) == 2'h1;
  assign wr_vco = psel_i && penable_i && pready_o && pwrite_i && decode(paddr_i) == 2'h2;
  assign wr_cap = psel_i && penable_i && pready_o && pwrite_i && decode(paddr_i) == 2'h3;
  assign clr    = rst_i || deep_sleep_wake_i;
  assign stage_on = charge_pump_cal_stage_enable != 2'h0;

  // ********************************
  // apb answer
  // ********************************
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0;
    end else begin
      pready_o  <= setup;
      pslverr_o <= setup && decode(paddr_i) == 2'h0;
      if (setup && !pwrite_i) begin
        case (decode(paddr_i))
          2'h1:    prdata_o <= {24'h0, cp_config, charge_pump_cal_stage_enable, cp_code};
          2'h2:    prdata_o <= {26'h0, vco_high_core_select, vco_current};
          2'h3:    prdata_o <= {26'h0, vco_cap};
          default: prdata_o <= 32'h0;
        endcase
      end else begin
        prdata_o <= 32'h0;
      end
    end
  end

  // ********************************
  // charge pump register
  // ********************************
  always_ff @(posedge clock_i) begin
    if (clr) begin
      cp_config                    <= RST_CP_CONFIG;
      charge_pump_cal_stage_enable <= RST_CP_STAGE_EN;
      cp_code                      <= RST_CP_CODE;
    end else begin
      if (wr_cp) begin
        cp_config                    <= pwdata_i[CP_CONFIG_LSB +: 2];
        charge_pump_cal_stage_enable <= pwdata_i[CP_STAGE_EN_LSB +: 2];
        cp_code                      <= pwdata_i[CP_CODE_LSB +: 4];
      end
      // with the stage enabled, a finishing calibration wins over a write to cp_code in the same cycle
      if (cal_done_i && stage_on) begin
        cp_code <= cal_cp_code_i;
      end
    end
  end

  // ********************************
  // vco current register
  // ********************************
  always_ff @(posedge clock_i) begin
    if (clr) begin
      vco_high_core_select <= RST_VCO_CORE;
      vco_current          <= RST_VCO_CURRENT;
    end else begin
      if (wr_vco) begin
        vco_high_core_select <= pwdata_i[VCO_CORE_BIT];
        vco_current          <= pwdata_i[VCO_CURRENT_LSB +: 5];
      end
      if (cal_done_i) begin
        vco_current <= cal_vco_current_i;
      end
    end
  end

  // ********************************
  // coarse tuning register
  // ********************************
  always_ff @(posedge clock_i) begin
    if (clr) begin
      vco_cap <= RST_VCO_CAP;
    end else if (cal_done_i) begin
      vco_cap <= cal_vco_cap_i;
    end else if (wr_cap) begin
      vco_cap <= pwdata_i[VCO_CAP_LSB +: 6];
    end
  end

  // ********************************
  // synthesizer controls
  // ********************************
  assign sc.code = cp_code;

  // outputs trail the registers by one cycle so each leaves a flip-flop
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cp_config_o                 <= RST_CP_CONFIG;
      charge_pump_cal_stage_run_o <= |RST_CP_STAGE_EN;
      cp_code_o                   <= RST_CP_CODE;
      cp_current_o                <= 12'h0;
      vco_high_core_select_o      <= RST_VCO_CORE;
      vco_current_o               <= RST_VCO_CURRENT;
      vco_cap_o                   <= RST_VCO_CAP;
    end else begin
      cp_config_o                 <= cp_config;
      charge_pump_cal_stage_run_o <= stage_on;
      cp_code_o                   <= cp_code;
      cp_current_o                <= sc.current;
      vco_high_core_select_o      <= vco_high_core_select;
      vco_current_o               <= vco_current;
      vco_cap_o                   <= vco_cap;
    end
  end

  // ********************************
  // checks
  // ********************************
  property p_wake_reset;
    @(posedge clock_i) disable iff (rst_i)
    deep_sleep_wake_i |=> cp_code == RST_CP_CODE && vco_current == RST_VCO_CURRENT
      && vco_cap == RST_VCO_CAP && charge_pump_cal_stage_enable == RST_CP_STAGE_EN;
  endproperty
  a_wake_reset: assert property (p_wake_reset)
    else $error("registers not at reset after wake");

  property p_stage_skip;
    @(posedge clock_i) disable iff (rst_i)
    (charge_pump_cal_stage_enable == 2'h0 && !clr) |=> !charge_pump_cal_stage_run_o;
  endproperty
  a_stage_skip: assert property (p_stage_skip)
    else $error("charge pump stage runs while disabled");

  property p_cp_scale;
    @(posedge clock_i) disable iff (rst_i)
    (cp_code == 4'h8 && !clr) |=> cp_current_o == 12'h400;
  endproperty
  a_cp_scale: assert property (p_cp_scale)
    else $error("charge pump current scale wrong");

  property p_core_select;
    @(posedge clock_i) disable iff (rst_i)
    (wr_vco && !clr) |=> ##1 vco_high_core_select_o == $past(pwdata_i[VCO_CORE_BIT], 2);
  endproperty
  a_core_select: assert property (p_core_select)
    else $error("vco core select not taken from write");

  property p_vco_override;
    @(posedge clock_i) disable iff (rst_i)
    (wr_vco && !cal_done_i && !clr) |=> vco_current == $past(pwdata_i[4:0]);
  endproperty
  a_vco_override: assert property (p_vco_override)
    else $error("vco current override lost");

  property p_cap_read_zero;
    @(posedge clock_i) disable iff (rst_i)
    (setup && !pwrite_i && decode(paddr_i) == 2'h3) |=> pready_o && prdata_o[31:6] == 26'h0;
  endproperty
  a_cap_read_zero: assert property (p_cap_read_zero)
    else $error("unused capacitor bits read nonzero");

  property p_restore_used;
    @(posedge clock_i) disable iff (rst_i)
    (wr_cap && !cal_done_i && !clr) ##1 !clr |=> vco_cap_o == $past(pwdata_i[5:0], 2);
  endproperty
  a_restore_used: assert property (p_restore_used)
    else $error("restored capacitor code not driven");

  property p_result_capture;
    @(posedge clock_i) disable iff (rst_i)
    (cal_done_i && !clr) |=> vco_cap == $past(cal_vco_cap_i)
      && vco_current == $past(cal_vco_current_i);
  endproperty
  a_result_capture: assert property (p_result_capture)
    else $error("calibration results not captured");

  property p_stage_hold;
    @(posedge clock_i) disable iff (rst_i)
    (cal_done_i && charge_pump_cal_stage_enable == 2'h0 && !wr_cp && !clr)
      |=> cp_code == $past(cp_code);
  endproperty
  a_stage_hold: assert property (p_stage_hold)
    else $error("charge pump code taken while stage disabled");

  property p_stage_run;
    @(posedge clock_i) disable iff (rst_i)
    (charge_pump_cal_stage_enable != 2'h0 && !clr) |=> charge_pump_cal_stage_run_o;
  endproperty
  a_stage_run: assert property (p_stage_run)
    else $error("charge pump stage idle while enabled");

  property p_cp_read;
    @(posedge clock_i) disable iff (rst_i)
    (setup && !pwrite_i && decode(paddr_i) == 2'h1) |=> prdata_o[31:8] == 24'h0
      && prdata_o[5:4] == $past(charge_pump_cal_stage_enable)
      && prdata_o[3:0] == $past(cp_code);
  endproperty
  a_cp_read: assert property (p_cp_read)
    else $error("charge pump read data wrong");

  property p_cp_frac;
    @(posedge clock_i) disable iff (rst_i)
    (cp_code == 4'h3 && !clr) |=> cp_current_o == 12'h1AF;
  endproperty
  a_cp_frac: assert property (p_cp_frac)
    else $error("charge pump fractional scale wrong");

  property p_core_wake;
    @(posedge clock_i) disable iff (rst_i)
    deep_sleep_wake_i |=> vco_high_core_select == RST_VCO_CORE && cp_config == RST_CP_CONFIG;
  endproperty
  a_core_wake: assert property (p_core_wake)
    else $error("core select or config not reset on wake");

  property p_core_keep;
    @(posedge clock_i) disable iff (rst_i)
    (cal_done_i && !wr_vco && !clr) |=> vco_high_core_select == $past(vco_high_core_select);
  endproperty
  a_core_keep: assert property (p_core_keep)
    else $error("calibration changed core select");

  property p_vco_read;
    @(posedge clock_i) disable iff (rst_i)
    (setup && !pwrite_i && decode(paddr_i) == 2'h2) |=> prdata_o[31:6] == 26'h0
      && prdata_o[5] == $past(vco_high_core_select) && prdata_o[4:0] == $past(vco_current);
  endproperty
  a_vco_read: assert property (p_vco_read)
    else $error("vco current read data wrong");

  property p_cp_write;
    @(posedge clock_i) disable iff (rst_i)
    (wr_cp && !cal_done_i && !clr) |=> cp_code == $past(pwdata_i[3:0])
      && charge_pump_cal_stage_enable == $past(pwdata_i[5:4])
      && cp_config == $past(pwdata_i[7:6]);
  endproperty
  a_cp_write: assert property (p_cp_write)
    else $error("restored charge pump value not taken");

  property p_cap_write;
    @(posedge clock_i) disable iff (rst_i)
    (wr_cap && !cal_done_i && !clr) |=> vco_cap == $past(pwdata_i[5:0]);
  endproperty
  a_cap_write: assert property (p_cap_write)
    else $error("restored capacitor value not taken");

  property p_cp_capture;
    @(posedge clock_i) disable iff (rst_i)
    (cal_done_i && stage_on && !clr) |=> cp_code == $past(cal_cp_code_i);
  endproperty
  a_cp_capture: assert property (p_cp_capture)
    else $error("charge pump result not captured");

endmodule // synth_calibration_regs

// [bench/synth_calibration_regs_tb_top.sv]
module synth_calibration_regs_tb_top
  import synth_cal_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ********************************
  // signals
  // ********************************
  logic                  clock_i;
  logic                  rst_i;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [APB_ADDR_W-1:0] paddr;
  logic [31:0]           pwdata;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  wake;
  logic                  cal_done;
  logic [3:0]            ccode;
  logic [4:0]            cvcur;
  logic [5:0]            ccap;
  logic [1:0]            cfg_o;
  logic                  run_o;
  logic [3:0]            code_o;
  logic [11:0]           curr_o;
  logic                  core_o;
  logic [4:0]            vcur_o;
  logic [5:0]            cap_o;
  logic [31:0]           rd;
  logic                  err;
  int                    errors;
  int                    cmp_count;

  synth_calibration_regs synth_calibration_regs_i (
    .clock_i(clock_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .deep_sleep_wake_i(wake), .cal_done_i(cal_done),
    .cal_cp_code_i(ccode), .cal_vco_current_i(cvcur), .cal_vco_cap_i(ccap),
    .cp_config_o(cfg_o), .charge_pump_cal_stage_run_o(run_o), .cp_code_o(code_o),
    .cp_current_o(curr_o), .vco_high_core_select_o(core_o), .vco_current_o(vcur_o),
    .vco_cap_o(cap_o));

  // ********************************
  // helpers
  // ********************************
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    if (errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [APB_ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    // no cycle count assumed: only the watchdog ends a stuck wait
    do begin
      @(posedge clock_i);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // q8 multiplier worked out from the exponential current law
  function automatic logic [11:0] cur(input logic [3:0] c);
    logic [8:0] f;
    case (c[1:0])
      2'h0: f = CP_FRAC_0;
      2'h1: f = CP_FRAC_1;
      2'h2: f = CP_FRAC_2;
      default: f = CP_FRAC_3;
    endcase
    return 12'(f) << c[3:2];
  endfunction

  // outputs lag the registers by one edge, so wait one before looking
  task automatic chk_all(input logic [7:0] cp, input logic [7:0] v, input logic [7:0] cap);
    @(posedge clock_i);
    #1;
    check({13'h0, cfg_o, run_o, code_o, core_o, vcur_o, cap_o},
          {13'h0, cp[7:6], |cp[5:4], cp[3:0], v[5:0], cap[5:0]});
    check({20'h0, curr_o}, {20'h0, cur(cp[3:0])});
    apb(1'b0, ADDR_CHARGE_PUMP_CAL, 32'h0);
    check(rd, {24'h0, cp});
    apb(1'b0, ADDR_VCO_CURRENT_CAL, 32'h0);
    check(rd, {26'h0, v[5:0]});
    apb(1'b0, ADDR_VCO_COARSE_CAP, 32'h0);
    check(rd, {26'h0, cap[5:0]});
  endtask

  task automatic cal(input logic [3:0] c, input logic [4:0] v, input logic [5:0] k);
    @(posedge clock_i);
    cal_done <= 1'b1;
    ccode    <= c;
    cvcur    <= v;
    ccap     <= k;
    @(posedge clock_i);
    cal_done <= 1'b0;
  endtask

  // ********************************
  // tests
  // ********************************
  initial begin
    logic [7:0] cp;
    errors = 0;
    cmp_count = 0;
    rst_i = 1'b1;
    {psel, penable, pwrite, wake, cal_done} = 5'h0;
    paddr = '0;
    pwdata = 32'h0;
    {ccode, cvcur, ccap} = 15'h0;
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    chk_all(8'hA9, 8'h0A, 8'h20);
    apb(1'b1, ADDR_CHARGE_PUMP_CAL, 32'hFFFFFFFF);
    apb(1'b1, ADDR_VCO_CURRENT_CAL, 32'hFFFFFFFF);
    apb(1'b1, ADDR_VCO_COARSE_CAP, 32'hFFFFFFFF);
    chk_all(8'hFF, 8'h3F, 8'h3F);
    // every code and every enable setting, including the skip setting
    for (int k = 0; k < 16; k++) begin
      cp = {k[1:0], k[3:2], k[3:0]};
      apb(1'b1, ADDR_CHARGE_PUMP_CAL, {24'h0, cp});
      chk_all(cp, 8'h3F, 8'h3F);
    end
    apb(1'b1, ADDR_CHARGE_PUMP_CAL, 32'h85);
    cal(4'hC, 5'h13, 6'h2B);
    chk_all(8'h85, 8'h33, 8'h2B);
    apb(1'b1, ADDR_CHARGE_PUMP_CAL, 32'h95);
    cal(4'h3, 5'h04, 6'h11);
    chk_all(8'h93, 8'h24, 8'h11);
    apb(1'b1, ADDR_CHARGE_PUMP_CAL, 32'h6C);
    apb(1'b1, ADDR_VCO_CURRENT_CAL, 32'h1F);
    apb(1'b1, ADDR_VCO_COARSE_CAP, 32'h05);
    chk_all(8'h6C, 8'h1F, 8'h05);
    apb(1'b1, ADDR_VCO_COARSE_CAP + 18'h4, 32'hFF);
    check({31'h0, err}, 32'h1);
    apb(1'b0, ADDR_VCO_COARSE_CAP + 18'h4, 32'h0);
    check({rd[31:1], err}, 32'h1);
    chk_all(8'h6C, 8'h1F, 8'h05);
    @(posedge clock_i);
    wake <= 1'b1;
    @(posedge clock_i);
    wake <= 1'b0;
    chk_all(8'hA9, 8'h0A, 8'h20);
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clock_i);
    errors++;
    conclude();
  end
endmodule // synth_calibration_regs_tb_top
